//--- zqpd_pkg.sv
// Constants, types and command helpers for the calibration and power-down sequencer
package zqpd_pkg;

  // ****************************************
  // Clock and timing figures
  // ****************************************
  localparam int CLK_MHZ       = 200;
  localparam int TZQINIT_NS    = 1000;
  localparam int TZQCL_NS      = 360;
  localparam int TZQCS_NS      = 90;
  localparam int TZQRESET_NS   = 50;
  localparam int TCKE_NS       = 15;
  localparam int TXP_NS        = 8;
  localparam int TDQSCK_MAX_NS = 6;
  localparam int TPD_MAX_NS    = 3900;
  localparam int RL_CYC        = 3;
  localparam int BURST_LEN     = 4;
  localparam int CNT_W         = 16;
  localparam int CA_W          = 20;

  // Least times and the read spacing round up, only the power-down limit rounds down
  localparam logic [CNT_W-1:0] ZQINIT_CYC  = CNT_W'((TZQINIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] ZQCL_CYC    = CNT_W'((TZQCL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] ZQCS_CYC    = CNT_W'((TZQCS_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] ZQRESET_CYC = CNT_W'((TZQRESET_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] TCKE_CYC    = CNT_W'((TCKE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] TXP_CYC     = CNT_W'((TXP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] TPD_MAX_CYC = CNT_W'((TPD_MAX_NS * CLK_MHZ) / 1000);
  localparam logic [CNT_W-1:0] PD_EXIT_CYC = (TXP_CYC > TCKE_CYC) ? TXP_CYC : TCKE_CYC;
  localparam logic [CNT_W-1:0] RD_PD_CYC   =
    CNT_W'(RL_CYC + (TDQSCK_MAX_NS * CLK_MHZ + 999) / 1000 + BURST_LEN / 2 + 1);
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
  localparam logic [1:0]       CLK_STABLE_CYC = 2'h2;

  // ****************************************
  // Command encodings
  // ****************************************
  localparam logic [7:0]      MR_ZQ_ADDR  = 8'h0a;
  localparam logic [7:0]      OP_ZQINIT   = 8'h10;
  localparam logic [7:0]      OP_ZQRESET  = 8'h20;
  localparam logic [7:0]      OP_ZQLONG   = 8'h30;
  localparam logic [7:0]      OP_ZQSHORT  = 8'h40;
  localparam logic [3:0]      MRW_CODE    = 4'h0;
  localparam logic [CA_W-1:0] CA_NOP      = 20'hfffff;

  typedef enum logic [1:0] {
    ZQ_INIT  = 2'b00,
    ZQ_RESET = 2'b01,
    ZQ_LONG  = 2'b10,
    ZQ_SHORT = 2'b11
  } zqpd_zq_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ZQ_BUSY  = 3'b001,
    ST_PD_ENTRY = 3'b010,
    ST_PD       = 3'b011,
    ST_PD_EXIT  = 3'b100
  } zqpd_state_t;

  // Calibration command: mode register write, fall half in [19:10], rise half in [9:0]
  function automatic logic [CA_W-1:0] zqpd_zq_ca(input zqpd_zq_kind_t kind);
    logic [7:0] op;
    unique case (kind)
      ZQ_INIT:  op = OP_ZQINIT;
      ZQ_RESET: op = OP_ZQRESET;
      ZQ_LONG:  op = OP_ZQLONG;
      ZQ_SHORT: op = OP_ZQSHORT;
    endcase
    return {op, MR_ZQ_ADDR[7:6], MR_ZQ_ADDR[5:0], MRW_CODE};
  endfunction

  // Busy period of each calibration variant
  function automatic logic [CNT_W-1:0] zqpd_zq_cyc(input zqpd_zq_kind_t kind);
    logic [CNT_W-1:0] cyc;
    unique case (kind)
      ZQ_INIT:  cyc = ZQINIT_CYC;
      ZQ_RESET: cyc = ZQRESET_CYC;
      ZQ_LONG:  cyc = ZQCL_CYC;
      ZQ_SHORT: cyc = ZQCS_CYC;
    endcase
    return cyc;
  endfunction

endpackage

//--- zqpd_timer.sv
// Loadable down-counter that flags expiry
`timescale 1ns/1ps
`default_nettype none
module zqpd_timer (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // Load and status
  input  wire logic                       load,
  input  wire logic [zqpd_pkg::CNT_W-1:0] load_val,
  output logic                            expired
);
  import zqpd_pkg::*;

  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - CNT_ONE;
    end
  end

  assign expired = (cnt_ff == '0);

endmodule
`default_nettype wire

//--- zqpd_ctl.sv
// Host sequencer for calibration commands and power-down entry and exit
// Overview of operation
// (RULE1) Device starts calibration on calibration write
// (RULE2) Initialization calibration issued before any other
// (RULE3) Reset variant restores default driver impedance
// (RULE4) No quiet bus after reset variant
// (RULE5) Calibrate only with all banks precharged
// (RULE6) Data bus quiet during measuring calibrations
// (RULE7) Only no-operations during calibration busy period
// (RULE8) Clock-enable high throughout calibration
// (RULE9) Shared resistor: measuring calibrations never overlap
// (RULE10) Device switches off calibration current afterwards
// (RULE11) No resistor: device ignores calibration commands
// (RULE12) Device enters power-down on clock-enable low
// (RULE13) No-operation in cycle after power-down entry
// (RULE14) No clock-enable low during register, read, write
// (RULE15) Device classes power-down as idle or active
// (RULE16) Device buffers off during power-down
// (RULE17) Clock-enable low at least minimum pulse time
// (RULE18) Power-down residency limited for refresh
// (RULE19) Exit: clock-enable high, chip select high
// (RULE20) Wait exit latency before executable command
// (RULE21) Clock stable two cycles before exit
// (RULE22) Read to power-down spacing respected
// (RULE23) Device counters refuse commands while busy
`timescale 1ns/1ps
`default_nettype none
module zqpd_ctl (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // Calibration requests
  input  wire logic                           zq_req,
  input  wire zqpd_pkg::zqpd_zq_kind_t        zq_kind,
  output logic                                zq_ready,
  output logic                                zq_done_ff,
  output logic                                calibrated_ff,
  // Calibration sharing and data bus status
  input  wire logic                           zq_share_busy,
  output logic                                zq_quiet_ff,
  // Power-down requests
  input  wire logic                           pd_req,
  input  wire logic                           access_busy,
  input  wire logic                           clk_stable_pin,
  // User command path
  input  wire logic                           banks_idle,
  input  wire logic                           user_cmd_valid,
  input  wire logic                           user_cmd_read,
  input  wire logic [zqpd_pkg::CA_W-1:0]      user_ca,
  output logic                                user_cmd_ready,
  // Device command pins
  output logic                                ck_en_ff,
  output logic                                cs_n_ff,
  output logic [zqpd_pkg::CA_W-1:0]           ca_ff
);
  import zqpd_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  zqpd_state_t      state_ff;
  zqpd_state_t      nxt_state;
  zqpd_zq_kind_t    zq_kind_ff;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic             tmr_done;
  logic             rd_done;
  logic             zq_legal;
  logic             zq_fire;
  logic             pd_fire;
  logic             user_fire;
  logic             rd_fire;
  logic             pd_leave;
  logic             clk_sync1_ff;
  logic             clk_sync2_ff;
  logic             clk_sync3_ff;
  logic             clk_ok_ff;
  logic [1:0]       stab_cnt_ff;
  logic [CNT_W-1:0] res_cnt_ff;

  // ****************************************
  // Clock-stable pin synchroniser
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_sync1_ff <= 1'b0;
      clk_sync2_ff <= 1'b0;
      clk_sync3_ff <= 1'b0;
    end else begin
      clk_sync1_ff <= clk_stable_pin;
      clk_sync2_ff <= clk_sync1_ff;
      clk_sync3_ff <= clk_sync2_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_ok_ff <= 1'b0;
    end else if (clk_sync2_ff == clk_sync3_ff) begin
      clk_ok_ff <= clk_sync3_ff;
    end
  end

  // Count cycles of stable clock before allowing exit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stab_cnt_ff <= 2'h0;
    end else if (!clk_ok_ff) begin
      stab_cnt_ff <= 2'h0;
    end else if (stab_cnt_ff != CLK_STABLE_CYC) begin
      stab_cnt_ff <= stab_cnt_ff + 2'h1;
    end
  end

  // ****************************************
  // Request arbitration
  // ****************************************
  always_comb begin
    zq_legal = banks_idle                                       // RULE5
               && (zq_kind == ZQ_RESET || !zq_share_busy)       // RULE9
               && (calibrated_ff || zq_kind == ZQ_INIT);        // RULE2
  end

  assign zq_ready       = (state_ff == ST_IDLE) && zq_legal;
  assign zq_fire        = zq_ready && zq_req;                   // RULE1
  assign pd_fire        = (state_ff == ST_IDLE) && !zq_req && pd_req
                          && !access_busy                       // RULE14
                          && rd_done;                           // RULE22
  assign user_cmd_ready = (state_ff == ST_IDLE) && !zq_req && !pd_fire;
  assign user_fire      = user_cmd_ready && user_cmd_valid;
  assign rd_fire        = user_fire && user_cmd_read;
  assign pd_leave       = tmr_done                              // RULE17
                          && (stab_cnt_ff == CLK_STABLE_CYC)    // RULE21
                          && (!pd_req || res_cnt_ff == '0);     // RULE18

  // ****************************************
  // State machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_val   = '0;
    unique case (state_ff)
      ST_IDLE: begin
        if (zq_fire) begin
          nxt_state = ST_ZQ_BUSY;
          tmr_load  = 1'b1;
          tmr_val   = zqpd_zq_cyc(zq_kind) - CNT_ONE;          // RULE7
        end else if (pd_fire) begin
          nxt_state = ST_PD_ENTRY;
        end
      end
      ST_ZQ_BUSY: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_PD_ENTRY: begin
        nxt_state = ST_PD;
        tmr_load  = 1'b1;
        tmr_val   = TCKE_CYC - CNT_ONE;                         // RULE17
      end
      ST_PD: begin
        if (pd_leave) begin
          nxt_state = ST_PD_EXIT;
          tmr_load  = 1'b1;
          tmr_val   = PD_EXIT_CYC - CNT_ONE;                    // RULE20
        end
      end
      ST_PD_EXIT: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  zqpd_timer u_tmr_main (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_done)
  );

  zqpd_timer u_tmr_rd (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (rd_fire),
    .load_val (RD_PD_CYC - CNT_ONE),                            // RULE22
    .expired  (rd_done)
  );

  // Residency limit while powered down
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      res_cnt_ff <= '0;
    end else if (pd_fire) begin
      res_cnt_ff <= TPD_MAX_CYC - CNT_ONE;                      // RULE18
    end else if (res_cnt_ff != '0) begin
      res_cnt_ff <= res_cnt_ff - CNT_ONE;
    end
  end

  // ****************************************
  // Calibration status
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zq_kind_ff    <= ZQ_INIT;
      zq_quiet_ff   <= 1'b0;
      zq_done_ff    <= 1'b0;
      calibrated_ff <= 1'b0;
    end else begin
      if (zq_fire) begin
        zq_kind_ff <= zq_kind;
      end
      zq_quiet_ff <= (nxt_state == ST_ZQ_BUSY)                  // RULE6
                     && ((zq_fire ? zq_kind : zq_kind_ff) != ZQ_RESET); // RULE4
      zq_done_ff  <= (state_ff == ST_ZQ_BUSY) && tmr_done;
      if (state_ff == ST_ZQ_BUSY && tmr_done && zq_kind_ff == ZQ_INIT) begin
        calibrated_ff <= 1'b1;                                  // RULE2
      end
    end
  end

  // ****************************************
  // Device pins
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ck_en_ff <= 1'b1;
      cs_n_ff  <= 1'b1;
      ca_ff    <= CA_NOP;
    end else begin
      ck_en_ff <= !(nxt_state == ST_PD_ENTRY || nxt_state == ST_PD); // RULE8
      cs_n_ff  <= !(zq_fire || user_fire);                       // RULE13
      if (zq_fire) begin
        ca_ff <= zqpd_zq_ca(zq_kind);                            // RULE1
      end else if (user_fire) begin
        ca_ff <= user_ca;
      end else begin
        ca_ff <= CA_NOP;                                         // RULE19
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence pd_entered_s;
    $fell(ck_en_ff);
  endsequence

  sequence pd_exited_s;
    $rose(ck_en_ff);
  endsequence

  cal_cke_high_a: assert property ((state_ff == ST_ZQ_BUSY) |-> ck_en_ff) // RULE8
    else $error("clock-enable low during calibration");
  cal_nop_only_a: assert property ((state_ff == ST_ZQ_BUSY) |=> cs_n_ff) // RULE7
    else $error("command issued during calibration");
  cal_quiet_bus_a: assert property (
    (state_ff == ST_ZQ_BUSY && zq_kind_ff != ZQ_RESET) |-> zq_quiet_ff) // RULE6
    else $error("data bus not held quiet during calibration");
  init_first_a: assert property (
    (zq_fire && zq_kind != ZQ_INIT) |-> calibrated_ff) // RULE2
    else $error("calibration before initialization calibration");
  pd_entry_nop_a: assert property (pd_entered_s |-> cs_n_ff ##1 cs_n_ff) // RULE13
    else $error("command in cycle after power-down entry");
  cke_low_min_a: assert property (pd_entered_s |-> !ck_en_ff [*3]) // RULE17
    else $error("clock-enable low pulse too short");
  exit_latency_a: assert property (pd_exited_s |-> (cs_n_ff && ck_en_ff) [*3]) // RULE20
    else $error("command or low clock-enable within exit latency");
  exit_clk_stable_a: assert property (
    pd_exited_s |-> $past(stab_cnt_ff) == CLK_STABLE_CYC) // RULE21
    else $error("power-down exit without stable clock");
  no_cke_access_a: assert property (pd_entered_s |-> !$past(access_busy)) // RULE14
    else $error("clock-enable lowered during access");
  read_to_pd_a: assert property (rd_fire |=> ck_en_ff [*8]) // RULE22
    else $error("power-down too soon after read");
  share_guard_a: assert property (
    (zq_fire && zq_kind != ZQ_RESET) |-> !zq_share_busy && banks_idle) // RULE9
    else $error("calibration overlaps shared resistor or open bank");

endmodule
`default_nettype wire

//--- zqpd_dev_model.sv
// Device model that decodes calibration and power-down and counts spacing faults
`timescale 1ns/1ps
`default_nettype none
module zqpd_dev_model #(
  parameter bit RES_FITTED = 1'b1
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Device pins
  input  wire logic                      ck_en,
  input  wire logic                      cs_n,
  input  wire logic [zqpd_pkg::CA_W-1:0] ca,
  input  wire logic                      banks_idle,
  // Observed state
  output logic                           in_pd_ff,
  output logic                           idle_pd_ff,
  output logic                           drv_default_ff,
  output logic [7:0]                     viol_ff
);
  import zqpd_pkg::*;
  logic             cke_q_ff;
  logic [CNT_W-1:0] busy_ff;
  logic [CNT_W-1:0] xp_ff;
  logic [CNT_W-1:0] len;
  logic             zq_hit;
  logic             bad;

  // ****************************************
  // Command decode
  // ****************************************
  // Commands are ignored in power-down and without a resistor
  assign zq_hit = RES_FITTED && !in_pd_ff && ck_en && !cs_n
                  && ca[11:0] == {MR_ZQ_ADDR, MRW_CODE};
  assign bad = (busy_ff != '0 && (!ck_en || !cs_n)) || (xp_ff != '0 && !cs_n)
               || (in_pd_ff && ck_en && !cs_n);
  always_comb begin
    case (ca[19:12])
      OP_ZQINIT:  len = ZQINIT_CYC;
      OP_ZQLONG:  len = ZQCL_CYC;
      OP_ZQSHORT: len = ZQCS_CYC;
      OP_ZQRESET: len = ZQRESET_CYC;
      default:    len = '0;
    endcase
  end

  // ****************************************
  // Power-down state
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cke_q_ff   <= 1'b1;
      in_pd_ff   <= 1'b0;
      idle_pd_ff <= 1'b0;
      xp_ff      <= '0;
    end else begin
      cke_q_ff <= ck_en;
      xp_ff    <= (xp_ff != '0) ? xp_ff - CNT_ONE : '0;
      if (cke_q_ff && !ck_en && cs_n && !in_pd_ff) begin
        in_pd_ff   <= 1'b1;
        idle_pd_ff <= banks_idle;
      end else if (in_pd_ff && ck_en) begin
        in_pd_ff <= 1'b0;
        xp_ff    <= TXP_CYC;
      end
    end
  end

  // ****************************************
  // Calibration busy and faults
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_ff        <= '0;
      drv_default_ff <= 1'b1;
      viol_ff        <= 8'h00;
    end else begin
      // Pin current only flows while busy
      busy_ff <= zq_hit ? len : ((busy_ff != '0) ? busy_ff - CNT_ONE : '0);
      if (zq_hit) begin
        drv_default_ff <= (ca[19:12] == OP_ZQRESET);
      end
      if (bad) begin
        viol_ff <= viol_ff + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- zq_cal_power_down_ctl_bench.sv
// Self-checking bench for the calibration and power-down sequencer
`timescale 1ns/1ps
`default_nettype none
module zq_cal_power_down_ctl_bench;
  import zqpd_pkg::*;
  logic sys_clk, rst, zq_req, zq_ready, zq_done_ff, calibrated_ff, zq_share_busy;
  logic zq_quiet_ff, pd_req, access_busy, clk_stable_pin, banks_idle;
  logic user_cmd_valid, user_cmd_read, user_cmd_ready, ck_en_ff, cs_n_ff;
  logic in_pd_ff, idle_pd_ff, drv_default_ff, nores_default;
  logic [7:0]      viol_ff;
  logic [CA_W-1:0] user_ca, ca_ff;
  zqpd_zq_kind_t   zq_kind;
  logic [CA_W-1:0] exp_ca[$];
  int              exp_gap[$];
  int n_errors, comparisons, cyc, t_cmd, k;
  logic [31:0] seed;

  zqpd_ctl zqpd_ctl_inst (.sys_clk(sys_clk), .rst(rst), .zq_req(zq_req), .zq_kind(zq_kind),
    .zq_ready(zq_ready), .zq_done_ff(zq_done_ff), .calibrated_ff(calibrated_ff),
    .zq_share_busy(zq_share_busy), .zq_quiet_ff(zq_quiet_ff), .pd_req(pd_req),
    .access_busy(access_busy), .clk_stable_pin(clk_stable_pin), .banks_idle(banks_idle),
    .user_cmd_valid(user_cmd_valid), .user_cmd_read(user_cmd_read), .user_ca(user_ca),
    .user_cmd_ready(user_cmd_ready), .ck_en_ff(ck_en_ff), .cs_n_ff(cs_n_ff), .ca_ff(ca_ff));
  zqpd_dev_model zqpd_dev_model_inst (.sys_clk(sys_clk), .rst(rst), .ck_en(ck_en_ff),
    .cs_n(cs_n_ff), .ca(ca_ff), .banks_idle(banks_idle), .in_pd_ff(in_pd_ff),
    .idle_pd_ff(idle_pd_ff), .drv_default_ff(drv_default_ff), .viol_ff(viol_ff));
  // Second device with no calibration resistor fitted
  zqpd_dev_model #(.RES_FITTED(1'b0)) nores_model_inst (.sys_clk(sys_clk), .rst(rst),
    .ck_en(ck_en_ff), .cs_n(cs_n_ff), .ca(ca_ff), .banks_idle(banks_idle), .in_pd_ff(),
    .idle_pd_ff(), .drv_default_ff(nores_default), .viol_ff());

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic bad(input string m);
    n_errors++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask
  task automatic cmp_ca(input logic [CA_W-1:0] g, input logic [CA_W-1:0] e);
    comparisons++;
    if (g !== e) bad($sformatf("command %h, expected %h", g, e));
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e) bad($sformatf("flag %b, expected %b", g, e));
  endtask
  task automatic cmp_num(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) bad($sformatf("count %0d, expected %0d", g, e));
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Output watcher and timeout
  // ****************************************
  always @(posedge sys_clk) begin
    cyc++;
    if (!rst && cs_n_ff === 1'b0) begin
      if (exp_ca.size() == 0) bad("unexpected command");
      else cmp_ca(ca_ff, exp_ca.pop_front());
      t_cmd = cyc;
    end
    if (!rst && zq_done_ff === 1'b1) begin
      if (exp_gap.size() == 0) bad("unexpected done");
      else cmp_num(cyc - t_cmd, exp_gap.pop_front());
    end
    if (cyc == 20000) begin
      bad("timeout");
      stop_test();
    end
  end

  // ****************************************
  // Stimulus tasks
  // ****************************************
  task automatic zq_cmd(input zqpd_zq_kind_t kd, input logic [7:0] op, input int n);
    int w;
    w = 0;
    zq_req  <= 1'b1;
    zq_kind <= kd;
    do begin @(posedge sys_clk); w++; end while (zq_ready !== 1'b1 && w < 500);
    exp_ca.push_back({op, MR_ZQ_ADDR, MRW_CODE});
    exp_gap.push_back(n);
    zq_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    cmp_bit(zq_quiet_ff, kd != ZQ_RESET);
    cmp_bit(ck_en_ff, 1'b1);
    do begin @(posedge sys_clk); w++; end while (zq_done_ff !== 1'b1 && w < 500);
    if (zq_done_ff !== 1'b1) bad("calibration wait timed out");
    cmp_bit(drv_default_ff, kd == ZQ_RESET);
  endtask
  task automatic burst(input int n, input logic rd);
    int w;
    w = 0;
    user_cmd_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      user_ca       <= seed[CA_W-1:0];
      user_cmd_read <= rd;
      do begin @(posedge sys_clk); w++; end while (user_cmd_ready !== 1'b1 && w < 900);
      exp_ca.push_back(user_ca);
    end
    if (w >= 900) bad("command wait timed out");
    user_cmd_valid <= 1'b0;
  endtask
  task automatic wait_ck(input logic lvl);
    k = 0;
    do begin @(posedge sys_clk); k++; end while (ck_en_ff !== lvl && k < 900);
    if (ck_en_ff !== lvl) bad("clock-enable wait timed out");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {zq_req, zq_share_busy, pd_req, access_busy, user_cmd_valid, user_cmd_read} = '0;
    {rst, clk_stable_pin, banks_idle} = 3'b111;
    zq_kind = ZQ_LONG;
    user_ca = CA_NOP;
    seed = 32'd93;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    cmp_ca(ca_ff, CA_NOP);
    cmp_bit(calibrated_ff, 1'b0);
    zq_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmp_bit(zq_ready, 1'b0);
    zq_cmd(ZQ_INIT, OP_ZQINIT, ZQINIT_CYC);
    cmp_bit(calibrated_ff, 1'b1);
    zq_share_busy <= 1'b1;
    zq_kind <= ZQ_SHORT;
    @(posedge sys_clk);
    cmp_bit(zq_ready, 1'b0);
    zq_cmd(ZQ_RESET, OP_ZQRESET, ZQRESET_CYC);
    zq_share_busy <= 1'b0;
    zq_cmd(ZQ_LONG, OP_ZQLONG, ZQCL_CYC);
    zq_cmd(ZQ_SHORT, OP_ZQSHORT, ZQCS_CYC);
    banks_idle <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    cmp_bit(zq_ready, 1'b0);
    burst(6, 1'b0);
    burst(1, 1'b1);
    // Clock reported unstable before entry so that exit must wait for it
    clk_stable_pin <= 1'b0;
    pd_req <= 1'b1;
    wait_ck(1'b0);
    cmp_bit(k >= RD_PD_CYC + 1, 1'b1);
    pd_req <= 1'b0;
    repeat (20) @(posedge sys_clk);
    cmp_bit(ck_en_ff, 1'b0);
    cmp_bit(in_pd_ff, 1'b1);
    cmp_bit(idle_pd_ff, 1'b0);
    clk_stable_pin <= 1'b1;
    wait_ck(1'b1);
    cmp_bit(k >= 5 && k <= 12, 1'b1);
    cmp_bit(user_cmd_ready, 1'b0);
    burst(2, 1'b0);
    banks_idle <= 1'b1;
    access_busy <= 1'b1;
    pd_req <= 1'b1;
    repeat (20) @(posedge sys_clk);
    cmp_bit(ck_en_ff, 1'b1);
    access_busy <= 1'b0;
    wait_ck(1'b0);
    pd_req <= 1'b0;
    wait_ck(1'b1);
    cmp_bit(k >= TCKE_CYC + 1, 1'b1);
    cmp_bit(idle_pd_ff, 1'b1);
    repeat (5) @(posedge sys_clk);
    pd_req <= 1'b1;
    wait_ck(1'b0);
    wait_ck(1'b1);
    pd_req <= 1'b0;
    cmp_bit(k <= TPD_MAX_CYC + 2, 1'b1);
    burst(1, 1'b0);
    repeat (10) @(posedge sys_clk);
    cmp_num(exp_ca.size() + exp_gap.size(), 0);
    cmp_num(viol_ff, 0);
    cmp_bit(in_pd_ff, 1'b0);
    cmp_bit(nores_default, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
